//--- inc/qdsf_pkg.sv
/*
  Constants and types for the quad converter serial frame input port.
  Assumes a single 100 MHz system clock; the serial pins arrive asynchronously.
*/
// Functional notes
// R1: The host never toggles frame sync twice without a full serial clock pulse in between.
// R2: A sync toggle with no full clock pulse between edges puts the port into a lockup state.
// R3: Lockup ends when a valid full frame is written or sync is again driven correctly.
// R4: Data is shifted most significant bit first; an LSB-first host must mirror each byte.
// R5: The host sends three bytes with sync held low and raises sync after the third.
// R6: The host uses clock polarity 0, phase 1, so data is valid at the falling clock edge.
// R7: Each channel word is an unsigned 12-bit straight-binary code from 0000h to 0FFFh.
// R8: A frame acts only after exactly 24 bits while sync is low; shorter frames are dropped.
`default_nettype none
package qdsf_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam int CODE_W = 12;
  localparam int CTRL_W = 8;
  localparam int CODE_LSB = 4;
  localparam int CTRL_LSB = 16;
  localparam logic [FRAME_BITS-1:0] FRAME_RST = 24'h000000;
  localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MAX = 12'hFFF;
  // Synchroniser contents while sync idles high, so reset gives no false edge
  localparam logic [2:0] SYNC_IDLE = 3'h7;

  // ****************************************
  // Receiver states
  // ****************************************
  typedef enum logic [1:0] {
    QDSF_IDLE,
    QDSF_SHIFT,
    QDSF_LOCK
  } qdsf_state_t;

endpackage
`default_nettype wire

//--- logic/qdsf_buf.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes source and sink share the clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module qdsf_buf #(
  parameter int WIDTH = 20
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] count;
    logic rd;
    logic wr;
    logic ov;
    logic ir;
    logic [WIDTH-1:0] od;
  } qdsf_buf_t;

  qdsf_buf_t cur;
  qdsf_buf_t nxt;
  logic push;
  logic pop;

  // ****************************************
  // Push, pop and pointer update
  // ****************************************
  always_comb begin
    nxt = cur;
    push = in_valid && (cur.count != 2'h2);
    pop = out_ready && (cur.count != 2'h0);
    if (push) begin
      nxt.mem[cur.wr] = in_data;
      nxt.wr = ~cur.wr;
    end
    if (pop) begin
      nxt.rd = ~cur.rd;
    end
    nxt.count = cur.count + {1'b0, push} - {1'b0, pop};
    // Flags and head word are registered so the outputs come from flops
    nxt.ov = (nxt.count != 2'h0);
    nxt.ir = (nxt.count != 2'h2);
    nxt.od = nxt.mem[nxt.rd];
  end

  // Registered state
  always_ff @(posedge mclk) begin
    if (reset) begin
      cur <= '0;
      cur.ir <= 1'b1; // Empty buffer accepts a word
    end else begin
      cur <= nxt;
    end
  end

  assign in_ready = cur.ir;
  assign out_valid = cur.ov;
  assign out_data = cur.od;
endmodule
`default_nettype wire

//--- logic/qdsf_port.sv
/*
  Serial frame receiver of a quad 12-bit converter: samples sync, clock and
  data pins on mclk, collects 24-bit frames MSB first when not in lockup, and
  hands each whole frame's control byte and code word to the converter core
  through a buffer, except a frame that finds the buffer full, which sets overrun.
  Assumes mclk runs well above the serial clock (at least four samples per
  serial clock phase) and that the core drains the buffer with frame_ready.
*/
`timescale 1ns/1ps
`default_nettype none
module qdsf_port
  import qdsf_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdin,
  output logic frame_valid,
  input wire logic frame_ready,
  output logic [qdsf_pkg::CTRL_W-1:0] frame_ctrl,
  output logic [qdsf_pkg::CODE_W-1:0] frame_code,
  output logic lockup,
  output logic overrun
);
  import qdsf_pkg::*;

  typedef struct packed {
    logic [2:0] sync_s;
    logic [2:0] sclk_s;
    logic [1:0] sdin_s;
    qdsf_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [FRAME_BITS-1:0] shreg;
    logic rose;
    logic push;
    logic [FRAME_BITS-1:0] word;
    logic lock;
    logic ovr;
  } qdsf_port_t;

  qdsf_port_t cur;
  qdsf_port_t nxt;
  logic sync_lo;
  logic sclk_fall;
  logic sclk_rise;
  logic sync_fall;
  logic sync_rise;
  logic buf_ready;
  logic bo_valid;
  logic [CTRL_W+CODE_W-1:0] bo_data;

  // ****************************************
  // Pin edges seen after two-flop synchronisers
  // ****************************************
  assign sync_lo = ~cur.sync_s[1];
  assign sync_fall = cur.sync_s[2] & ~cur.sync_s[1];
  assign sync_rise = ~cur.sync_s[2] & cur.sync_s[1];
  assign sclk_fall = cur.sclk_s[2] & ~cur.sclk_s[1];
  assign sclk_rise = ~cur.sclk_s[2] & cur.sclk_s[1];

  // ****************************************
  // Frame receiver
  // ****************************************
  always_comb begin
    nxt = cur;
    nxt.sync_s = {cur.sync_s[1:0], sync_n};
    nxt.sclk_s = {cur.sclk_s[1:0], sclk};
    nxt.sdin_s = {cur.sdin_s[0], sdin};
    nxt.push = 1'b0;
    if (sclk_rise) begin
      nxt.rose = 1'b1; // A rising edge begins a full clock pulse
    end
    case (cur.state)
      QDSF_IDLE: begin
        if (sync_fall) begin
          nxt.state = QDSF_SHIFT;
          nxt.cnt = CNT_ZERO;
          nxt.rose = 1'b0;
        end
      end
      QDSF_SHIFT: begin
        if (sync_rise) begin
          // Sync back high before one full pulse is a misuse [R2]
          if (cur.cnt == CNT_ZERO) begin
            nxt.state = QDSF_LOCK; // [R2]
            nxt.lock = 1'b1;
          end else begin
            nxt.state = QDSF_IDLE; // Short frame dropped [R8]
          end
        end else if (sclk_fall && sync_lo) begin
          // Data valid at the falling edge, shifted in MSB first [R4] [R6]
          nxt.shreg = {cur.shreg[FRAME_BITS-2:0], cur.sdin_s[1]};
          nxt.cnt = cur.cnt + 5'h01;
          if (cur.cnt == CNT_FULL - 5'h01) begin
            // Exactly 24 bits act on the frame; a valid command also clears lockup [R8] [R3]
            nxt.word = {cur.shreg[FRAME_BITS-2:0], cur.sdin_s[1]};
            nxt.push = 1'b1;
            nxt.lock = 1'b0; // [R3]
            nxt.state = QDSF_IDLE;
          end
        end
      end
      QDSF_LOCK: begin
        // Lockup holds until sync falls and stays low over a full pulse [R3]
        if (sync_fall) begin
          nxt.rose = 1'b0;
        end else if (sync_lo && cur.rose && sclk_fall) begin
          nxt.lock = 1'b0; // [R3]
          nxt.state = QDSF_IDLE; // Host resyncs with a fresh frame
        end
      end
      default: begin
        nxt.state = QDSF_IDLE;
      end
    endcase
    // Frames that find the buffer full are counted as overrun, sticky until reset
    if (cur.push && !buf_ready) begin
      nxt.ovr = 1'b1;
    end
  end

  // Registered state; sync idles high at reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      cur <= '0;
      cur.sync_s <= SYNC_IDLE;
      cur.state <= QDSF_IDLE;
      cur.shreg <= FRAME_RST;
      cur.word <= FRAME_RST;
    end else begin
      cur <= nxt;
    end
  end

  // ****************************************
  // Output buffer: control byte and 12-bit straight binary code [R7]
  // ****************************************
  qdsf_buf #(
    .WIDTH(CTRL_W + CODE_W)
  ) u_buf (
    .mclk(mclk),
    .reset(reset),
    .in_valid(cur.push),
    .in_ready(buf_ready),
    .in_data({cur.word[CTRL_LSB+CTRL_W-1:CTRL_LSB], cur.word[CODE_LSB+CODE_W-1:CODE_LSB]}),
    .out_valid(bo_valid),
    .out_ready(frame_ready),
    .out_data(bo_data)
  );

  assign frame_valid = bo_valid;
  assign frame_ctrl = bo_data[CTRL_W+CODE_W-1:CODE_W];
  assign frame_code = bo_data[CODE_W-1:0]; // [R7]
  assign lockup = cur.lock;
  assign overrun = cur.ovr;
endmodule
`default_nettype wire

//--- verif/qdsf_chk.sv
/* Port checker for the serial frame input port.
   Sees only the ports of qdsf_port; bound to it below. */
`timescale 1ns/1ps
`default_nettype none
module qdsf_chk
  import qdsf_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic frame_valid,
  input wire logic frame_ready,
  input wire logic [qdsf_pkg::CTRL_W-1:0] frame_ctrl,
  input wire logic [qdsf_pkg::CODE_W-1:0] frame_code,
  input wire logic lockup,
  input wire logic overrun
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // A stalled head frame keeps its valid flag and contents
  chk_head_hold:
    assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_ctrl)
      && $stable(frame_code)) else $error("head frame changed while stalled");
  // Reset empties the buffer and clears both flags
  chk_reset_clear:
    assert property (disable iff (1'b0) reset |=> !frame_valid && !lockup && !overrun)
      else $error("flags not cleared by reset");
  // Lockup is entered only once sync has gone back high
  chk_lock_entry:
    assert property ($rose(lockup) |-> sync_n) else $error("lockup set while sync low");
  // Lockup is left only while the host drives sync low again
  chk_lock_exit:
    assert property ($fell(lockup) |-> !sync_n) else $error("lockup left without sync low");
  // A lost frame stays flagged until reset
  chk_overrun_sticky:
    assert property (overrun |=> overrun) else $error("overrun flag dropped");
  cover property (frame_valid && frame_ready);
  cover property ($rose(lockup));
  cover property ($rose(overrun));
endmodule
bind qdsf_port qdsf_chk i_qdsf_chk (.mclk(mclk), .reset(reset), .sync_n(sync_n), .sclk(sclk),
  .sdin(sdin), .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_ctrl(frame_ctrl),
  .frame_code(frame_code), .lockup(lockup), .overrun(overrun));
`default_nettype wire

//--- verif/qdsf_host.sv
/* Host model: drives sync, serial clock and data of the frame port.
   Assumes the bench calls its tasks; pins change at mclk falling edges. */
`timescale 1ns/1ps
`default_nettype none
module qdsf_host (
  input wire logic mclk,
  output logic sync_n,
  output logic sclk,
  output logic sdin
);
  // Idle pins: sync high, clock low
  initial begin
    sync_n = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
  end
  // Sends the top n bits of w, ph mclk cycles per clock phase
  task automatic send(input logic [23:0] w, input int n, input int ph);
    @(negedge mclk) sync_n = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      repeat (ph) @(negedge mclk);
      sclk = 1'b1;
      sdin = w[i];
      repeat (ph) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (ph) @(negedge mclk);
    sync_n = 1'b1;
    sdin = ~sdin;
  endtask
  // Sync pulse with no clock pulse inside, on the bench's command
  task automatic glitch();
    @(negedge mclk) sync_n = 1'b0;
    repeat (6) @(negedge mclk);
    sync_n = 1'b1;
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
/* Self-checking bench for qdsf_port.
   Assumes qdsf_host in verif/ and the checker bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qdsf_pkg::*;
  logic mclk, reset, sync_n, sclk, sdin, frame_valid, frame_ready, lockup, overrun;
  logic [CTRL_W-1:0] frame_ctrl;
  logic [CODE_W-1:0] frame_code;
  int fails = 0;
  int checked = 0;
  qdsf_port i_qdsf_port (.mclk(mclk), .reset(reset), .sync_n(sync_n), .sclk(sclk), .sdin(sdin),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_ctrl(frame_ctrl),
    .frame_code(frame_code), .lockup(lockup), .overrun(overrun));
  qdsf_host i_qdsf_host (.mclk(mclk), .sync_n(sync_n), .sclk(sclk), .sdin(sdin));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Compares and counts
  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Waits for the head frame, checks it and pops it
  task automatic take(input logic [23:0] w);
    for (int i = 0; i < 400 && frame_valid !== 1'b1; i++) @(negedge mclk);
    chk("frame_valid", frame_valid, 1'b1);
    chk("frame_ctrl", frame_ctrl, w[23:16]);
    chk("frame_code", frame_code, w[15:4]);
    frame_ready = 1'b1;
    @(negedge mclk);
    frame_ready = 1'b0;
    // Let an edge pass so a following take does not re-raise ready at once
    @(negedge mclk);
  endtask
  // Three frames into a stalled two-entry buffer; third is lost
  task automatic t_buffer();
    i_qdsf_host.send(24'hA5000F, 24, 5);
    i_qdsf_host.send(24'h3CFFF0, 24, 9);
    i_qdsf_host.send(24'h111235, 24, 5);
    repeat (10) @(negedge mclk);
    chk("overrun", overrun, 1'b1);
    take(24'hA5000F);
    take(24'h3CFFF0);
    repeat (2) @(negedge mclk);
    chk("frame_valid", frame_valid, 1'b0);
  endtask
  // A 23-bit frame is dropped and causes no lockup
  task automatic t_short();
    i_qdsf_host.send(24'hFFFFFF, 23, 5);
    repeat (20) @(negedge mclk);
    chk("frame_valid", frame_valid, 1'b0);
    chk("lockup", lockup, 1'b0);
  endtask
  // Sync glitch locks up; a full frame recovers; next frame arrives
  task automatic t_lock();
    i_qdsf_host.glitch();
    repeat (10) @(negedge mclk);
    chk("lockup", lockup, 1'b1);
    i_qdsf_host.send(24'h000000, 24, 5);
    repeat (10) @(negedge mclk);
    chk("lockup", lockup, 1'b0);
    chk("frame_valid", frame_valid, 1'b0);
    frame_ready = 1'b1;
    repeat (3) @(negedge mclk);
    frame_ready = 1'b0;
    i_qdsf_host.send(24'h5A8018, 24, 5);
    take(24'h5A8018);
  endtask
  // Reset, scenarios, second reset clears the sticky flag
  initial begin
    reset = 1'b1;
    frame_ready = 1'b0;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    t_buffer();
    t_short();
    t_lock();
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    chk("overrun", overrun, 1'b0);
    end_sim();
  end
  // Watchdog well beyond the expected 17 us of traffic
  initial begin
    #200000;
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
